// file: core/sgot_pkg.sv
// constants for the trim controller: device addresses, field values, register map
// assumes an 8-bit device register port and a 32-bit classic wishbone slave
package sgot_pkg;
    // device register addresses
    localparam logic [7:0] ADDR_REC1_N   = 8'h09;
    localparam logic [7:0] ADDR_REC2_N   = 8'h0a;
    localparam logic [7:0] ADDR_REC3_N   = 8'h0b;
    localparam logic [7:0] ADDR_REC1_R   = 8'h0c;
    localparam logic [7:0] ADDR_REC2_R   = 8'h0d;
    localparam logic [7:0] ADDR_REC3_R   = 8'h0e;
    localparam logic [7:0] ADDR_OFFS_NVM = 8'h19;
    localparam logic [7:0] ADDR_COARSE   = 8'h51;
    localparam logic [7:0] ADDR_TC       = 8'h55;
    localparam logic [7:0] ADDR_OFFS_IMG = 8'h59;
    localparam logic [7:0] ADDR_FINE_HI  = 8'h5a;
    // coefficient field extremes, 6-bit two's complement
    localparam logic [5:0] TC_MIN = 6'h21;
    localparam logic [5:0] TC_MAX = 6'h1f;
    localparam int         TC_LIM = 31;
    // gain search
    localparam logic [2:0] GAIN_TOP      = 3'h7;
    localparam logic [2:0] STEP_LAST_IDX = 3'h6;
    localparam logic signed [31:0] CORR_STEP6 = -32'sh101;
    localparam logic signed [31:0] CORR_STEP7 = -32'sh156;
    // offset drift: weights in thousandths, result scaled by 8000
    localparam logic signed [15:0] W_STEP3  = 16'sh03e8;
    localparam logic signed [15:0] W_STEP4  = 16'sh05dc;
    localparam logic signed [15:0] W_STEP5  = 16'sh06d6;
    localparam logic signed [15:0] W_STEP6  = 16'sh0753;
    localparam logic signed [15:0] W_STEP7  = 16'sh0792;
    localparam logic signed [15:0] W_UNIT   = 16'sh03e8;
    localparam logic signed [15:0] OFFS_DEN = 16'sh1f40;
    localparam int                 OFFS_LIM = 15;
    // wishbone register byte offsets
    localparam logic [5:0] REG_CTRL  = 6'h00;
    localparam logic [5:0] REG_SENS  = 6'h04;
    localparam logic [5:0] REG_FIELD = 6'h08;
    localparam logic [5:0] REG_CTGT  = 6'h0c;
    localparam logic [5:0] REG_CSTEP = 6'h10;
    localparam logic [5:0] REG_STAT  = 6'h14;
endpackage : sgot_pkg

// file: core/sgot_div.sv
// sequential signed divider, result rounded half away from zero
// assumes den_i nonzero; num_i and den_i sampled only at start_i
`timescale 1ns/1ps
`default_nettype none
module sgot_div #(
    parameter int NW = 32,
    parameter int DW = 16
) (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // request
    input  wire logic                 start_i,
    input  wire logic signed [NW-1:0] num_i,
    input  wire logic [DW-1:0]        den_i,
    // answer
    output logic                      busy_o,
    output logic                      done_o,
    output logic signed [NW-1:0]      quo_o
);
    localparam int AW = NW + 1;
    localparam int CW = $clog2(AW + 1);
    if (DW >= NW) begin : g_bad_width
        $error("sgot_div: DW must be below NW");
    end
    logic [AW-1:0] acc_q;
    logic [DW:0]   rem_q;
    logic [DW-1:0] den_q;
    logic          neg_q;
    logic [CW-1:0] cnt_q;
    wire  [NW-1:0] mag_w   = num_i[NW-1] ? NW'(-num_i) : NW'(num_i);
    // half the divisor added up front gives the rounding for free
    wire  [AW-1:0] load_w  = {1'b0, mag_w} + AW'(den_i >> 1);
    wire  [DW:0]   rem_sh  = {rem_q[DW-1:0], acc_q[AW-1]};
    wire           ge_w    = rem_sh >= {1'b0, den_q};
    wire  [NW-1:0] res_w   = acc_q[NW-1:0];
    assign quo_o = neg_q ? $signed(-res_w) : $signed(res_w);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_q  <= '0;
            rem_q  <= '0;
            den_q  <= '0;
            neg_q  <= 1'b0;
            cnt_q  <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i && !busy_o) begin
                acc_q  <= load_w;
                rem_q  <= '0;
                den_q  <= den_i;
                neg_q  <= num_i[NW-1];
                cnt_q  <= CW'(AW);
                busy_o <= 1'b1;
            end else if (busy_o) begin
                acc_q <= {acc_q[AW-2:0], ge_w};
                rem_q <= ge_w ? rem_sh - {1'b0, den_q} : rem_sh;
                cnt_q <= cnt_q - 1'b1;
                if (cnt_q == CW'(1)) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end
endmodule : sgot_div
`default_nettype wire

// file: core/sgot_offs.sv
// offset drift arithmetic: record decode, scaled numerator, saturating encoder
// assumes records already chosen for the active polarity
`timescale 1ns/1ps
`default_nettype none
module sgot_offs
    import sgot_pkg::*;
(
    // selection
    input  wire logic [2:0]         step_i,
    // shipment records, sign-magnitude, sign 1 = positive
    input  wire logic [4:0]         rec1_i,
    input  wire logic [7:0]         rec2_i,
    input  wire logic [7:0]         rec3_i,
    // numerator scaled by the divisor constant
    output logic signed [31:0]      num_o,
    // rounded quotient in, encoded trim out
    input  wire logic signed [31:0] quo_i,
    output logic [4:0]              code_o
);
    wire signed [31:0] r1 = rec1_i[4] ? 32'(rec1_i[3:0]) : -32'(rec1_i[3:0]);
    wire signed [31:0] r2 = rec2_i[7] ? 32'(rec2_i[6:0]) : -32'(rec2_i[6:0]);
    wire signed [31:0] r3 = rec3_i[7] ? 32'(rec3_i[6:0]) : -32'(rec3_i[6:0]);
    wire signed [15:0] w3 = (step_i == 3'h3) ? W_STEP3 :
                            (step_i == 3'h4) ? W_STEP4 :
                            (step_i == 3'h5) ? W_STEP5 :
                            (step_i == 3'h6) ? W_STEP6 : W_STEP7;
    wire signed [31:0] u  = 32'(W_UNIT);
    // step one uses the record as is, step two the second record over eight
    assign num_o = (step_i == 3'h1) ? 32'(r1 * 32'(OFFS_DEN)) :
                   (step_i == 3'h2) ? 32'(r2 * u) :
                   32'(r2 * u - r3 * 32'(w3));
    // clamp keeps the magnitude in four bits so the sign bit stays clean
    wire signed [31:0] lim = OFFS_LIM;
    wire signed [31:0] sat = (quo_i > lim) ? lim : (quo_i < -lim) ? -lim : quo_i;
    wire        [31:0] mag = sat[31] ? 32'(-sat) : 32'(sat);
    assign code_o = {~sat[31], mag[3:0]};
endmodule : sgot_offs
`default_nettype wire

// file: core/sgot_ctrl.sv
// trimming controller: coarse gain search, drift coefficient, offset drift trim
// assumes a device register port with req/ack and an external measurement unit
// How it works
// - write coefficient -31 then 31, two samples each
// - field writes keep bit7 zero, bit0 polarity
// - sensitivity is output delta over nominal field
// - stop when both pass; give up at six
// - coefficient is target plus step correction over step
// - coefficient result rounded to nearest integer
// - trim is sign-magnitude, sign one positive
// - recompute trim after gain and polarity settle
// - polarity bit picks which record set is read
// - trim formula depends on coarse step
// - third record weights 1 to 1.938
// - trim result rounded to nearest integer
// - keep 5Ah bits 7..5 in 59h upper bits
`timescale 1ns/1ps
`default_nettype none
module sgot_ctrl
    import sgot_pkg::*;
#(
    parameter int MW = 16
) (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // wishbone slave
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [7:0]    wb_adr_i,
    input  wire logic [31:0]   wb_dat_i,
    input  wire logic [3:0]    wb_sel_i,
    output logic [31:0]        wb_dat_o,
    output logic               wb_ack_o,
    // device register port
    output logic               dev_req_o,
    output logic               dev_we_o,
    output logic [7:0]         dev_addr_o,
    output logic [7:0]         dev_wdata_o,
    input  wire logic [7:0]    dev_rdata_i,
    input  wire logic          dev_ack_i,
    // output pin measurement
    output logic               meas_req_o,
    output logic               meas_nominal_o,
    input  wire logic [MW-1:0] meas_data_i,
    input  wire logic          meas_ack_i
);
    if (MW < 8 || MW > 31) begin : g_bad_mw
        $error("sgot_ctrl: MW out of range");
    end
    typedef enum logic [3:0] {
        S_IDLE, S_COARSE, S_TC, S_MEAS, S_CHECK, S_CDIV, S_CWAIT, S_CWR,
        S_REC1, S_REC2, S_REC3, S_KEEP, S_ODIV, S_OWAIT, S_OWR
    } sgot_state_t;
    sgot_state_t state_q, state_d;
    logic [2:0]  idx_q, idx_d;
    logic [1:0]  k_q, k_d;
    logic        rev_q, rev_run_q, done_q, unreach_q;
    logic [15:0] sens_q, field_q, cstep_q;
    logic [15:0] ctgt_q;
    logic [5:0]  coef_q;
    logic [4:0]  offs_q, rec1_q;
    logic [7:0]  rec2_q, rec3_q;
    logic [2:0]  keep_q;
    logic [MW-1:0] samp_q [4];
    logic        we_d;
    logic [7:0]  addr_d, wdat_d;

    // wishbone decode
    wire acc_w   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr_w    = acc_w && wb_we_i;
    wire [5:0] a = wb_adr_i[5:0];
    wire start_w = wr_w && a == REG_CTRL && wb_sel_i[0] && wb_dat_i[0];
    wire busy_w  = state_q != S_IDLE;
    wire [2:0] gstep = GAIN_TOP - idx_q;
    wire [31:0] stat_w = {15'h0, unreach_q, done_q, busy_w, gstep, coef_q, offs_q};
    wire [31:0] rd_w = (a == REG_CTRL)  ? {30'h0, rev_q, 1'b0} :
                       (a == REG_SENS)  ? {16'h0, sens_q} :
                       (a == REG_FIELD) ? {16'h0, field_q} :
                       (a == REG_CTGT)  ? {16'h0, ctgt_q} :
                       (a == REG_CSTEP) ? {16'h0, cstep_q} :
                       (a == REG_STAT)  ? stat_w : 32'h0;
    function automatic logic [15:0] merge16(input logic [15:0] o, input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
    endfunction : merge16

    // sensitivity test: delta > target times field avoids a divide
    wire signed [MW:0] dm = $signed({samp_q[2][MW-1], samp_q[2]}) - $signed({samp_q[0][MW-1], samp_q[0]});
    wire signed [MW:0] dp = $signed({samp_q[3][MW-1], samp_q[3]}) - $signed({samp_q[1][MW-1], samp_q[1]});
    wire [31:0] thr   = sens_q * field_q;
    wire signed [32:0] thr_s = $signed({1'b0, thr});
    wire pass_w = (33'(dm) > thr_s) && (33'(dp) > thr_s);

    // divider shared by both computations
    wire signed [31:0] corr = (gstep == GAIN_TOP) ? CORR_STEP7 :
                              (gstep == 3'h6) ? CORR_STEP6 : 32'sh0;
    wire signed [31:0] cnum = 32'($signed(ctgt_q)) + corr;
    wire signed [31:0] onum, quo;
    wire        [4:0]  ocode;
    wire div_done;
    wire coef_ph = (state_q == S_CDIV);
    sgot_div #(.NW(32), .DW(16)) u_div (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (state_q == S_CDIV || state_q == S_ODIV),
        .num_i   (coef_ph ? cnum : onum),
        .den_i   (coef_ph ? cstep_q : OFFS_DEN),
        .busy_o  (),
        .done_o  (div_done),
        .quo_o   (quo)
    );
    sgot_offs u_offs (
        .step_i (gstep),
        .rec1_i (rec1_q),
        .rec2_i (rec2_q),
        .rec3_i (rec3_q),
        .num_o  (onum),
        .quo_i  (quo),
        .code_o (ocode)
    );
    wire signed [31:0] tlim = TC_LIM;
    wire [5:0] coef_sat = (quo > tlim) ? TC_MAX : (quo < -tlim) ? TC_MIN : quo[5:0];

    // sequencer
    always_comb begin
        state_d = state_q;
        idx_d   = idx_q;
        k_d     = k_q;
        case (state_q)
            S_IDLE:   if (start_w) begin
                state_d = S_COARSE;
                idx_d   = 3'h0;
                k_d     = 2'h0;
            end
            S_COARSE: if (dev_ack_i) state_d = S_TC;
            S_TC:     if (dev_ack_i) state_d = S_MEAS;
            S_MEAS:   if (meas_ack_i) begin
                k_d     = k_q + 2'h1;
                state_d = (k_q == 2'h3) ? S_CHECK : S_TC;
            end
            S_CHECK:  if (pass_w) state_d = S_CDIV;
                else if (idx_q < STEP_LAST_IDX) begin
                    idx_d   = idx_q + 3'h1;
                    state_d = S_COARSE;
                end else state_d = S_IDLE;
            S_CDIV:   state_d = S_CWAIT;
            S_CWAIT:  if (div_done) state_d = S_CWR;
            S_CWR:    if (dev_ack_i) state_d = S_REC1;
            S_REC1:   if (dev_ack_i) state_d = S_REC2;
            S_REC2:   if (dev_ack_i) state_d = S_REC3;
            S_REC3:   if (dev_ack_i) state_d = S_KEEP;
            S_KEEP:   if (dev_ack_i) state_d = S_ODIV;
            S_ODIV:   state_d = S_OWAIT;
            S_OWAIT:  if (div_done) state_d = S_OWR;
            S_OWR:    if (dev_ack_i) state_d = S_IDLE;
            default:  state_d = S_IDLE;
        endcase
    end

    // device access for the state about to be entered
    always_comb begin
        we_d   = 1'b1;
        addr_d = 8'h0;
        wdat_d = 8'h0;
        case (state_d)
            S_COARSE: begin
                addr_d = ADDR_COARSE;
                wdat_d = {5'h0, GAIN_TOP - idx_d};
            end
            S_TC: begin
                addr_d = ADDR_TC;
                wdat_d = {1'b0, k_d[0] ? TC_MAX : TC_MIN, rev_run_q};
            end
            S_CWR: begin
                addr_d = ADDR_TC;
                wdat_d = {1'b0, coef_sat, rev_run_q};
            end
            S_REC1: begin
                we_d   = 1'b0;
                addr_d = rev_run_q ? ADDR_REC1_R : ADDR_REC1_N;
            end
            S_REC2: begin
                we_d   = 1'b0;
                addr_d = rev_run_q ? ADDR_REC2_R : ADDR_REC2_N;
            end
            S_REC3: begin
                we_d   = 1'b0;
                addr_d = rev_run_q ? ADDR_REC3_R : ADDR_REC3_N;
            end
            S_KEEP: begin
                we_d   = 1'b0;
                addr_d = ADDR_FINE_HI;
            end
            S_OWR: begin
                addr_d = ADDR_OFFS_IMG;
                wdat_d = {keep_q, ocode};
            end
            default: we_d = 1'b0;
        endcase
    end

    assign dev_req_o  = state_q inside {S_COARSE, S_TC, S_CWR, S_REC1, S_REC2, S_REC3, S_KEEP, S_OWR};
    assign meas_req_o = state_q == S_MEAS;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= S_IDLE;
            idx_q   <= 3'h0;
            k_q     <= 2'h0;
            dev_we_o    <= 1'b0;
            dev_addr_o  <= 8'h0;
            dev_wdata_o <= 8'h0;
            meas_nominal_o <= 1'b0;
        end else begin
            state_q <= state_d;
            idx_q   <= idx_d;
            k_q     <= k_d;
            dev_we_o    <= we_d;
            dev_addr_o  <= addr_d;
            dev_wdata_o <= wdat_d;
            meas_nominal_o <= k_d[1];
        end
    end

    // captured results; samples need no reset, they are rewritten each step
    always_ff @(posedge clk_i) begin
        if (state_q == S_MEAS && meas_ack_i) samp_q[k_q] <= meas_data_i;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            coef_q <= 6'h0;
            offs_q <= 5'h0;
            rec1_q <= 5'h0;
            rec2_q <= 8'h0;
            rec3_q <= 8'h0;
            keep_q <= 3'h0;
        end else begin
            if (state_q == S_CWAIT && div_done) coef_q <= coef_sat;
            if (state_q == S_OWAIT && div_done) offs_q <= ocode;
            if (state_q == S_REC1 && dev_ack_i) rec1_q <= dev_rdata_i[4:0];
            if (state_q == S_REC2 && dev_ack_i) rec2_q <= dev_rdata_i;
            if (state_q == S_REC3 && dev_ack_i) rec3_q <= dev_rdata_i;
            if (state_q == S_KEEP && dev_ack_i) keep_q <= dev_rdata_i[7:5];
        end
    end

    // software registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rev_q <= 1'b0;
            rev_run_q <= 1'b0;
            sens_q <= 16'h0;
            field_q <= 16'h0;
            ctgt_q <= 16'h0;
            cstep_q <= 16'h1;
            done_q <= 1'b0;
            unreach_q <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= acc_w;
            if (acc_w) wb_dat_o <= rd_w;
            // polarity is frozen per run so a mid-run write cannot split the record set
            if (wr_w && a == REG_CTRL && wb_sel_i[0]) rev_q <= wb_dat_i[1];
            if (wr_w && a == REG_SENS)  sens_q  <= merge16(sens_q, wb_dat_i, wb_sel_i);
            if (wr_w && a == REG_FIELD) field_q <= merge16(field_q, wb_dat_i, wb_sel_i);
            if (wr_w && a == REG_CTGT)  ctgt_q  <= merge16(ctgt_q, wb_dat_i, wb_sel_i);
            if (wr_w && a == REG_CSTEP) cstep_q <= merge16(cstep_q, wb_dat_i, wb_sel_i);
            if (state_q == S_IDLE && start_w) begin
                // the start write carries the polarity itself; rev_q is still the old one here
                rev_run_q <= wb_dat_i[1];
                done_q    <= 1'b0;
                unreach_q <= 1'b0;
            end
            if (state_q == S_CHECK && !pass_w && idx_q == STEP_LAST_IDX) begin
                done_q    <= 1'b1;
                unreach_q <= 1'b1;
            end
            if (state_q == S_OWR && dev_ack_i) done_q <= 1'b1;
        end
    end

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_tc_frame;
        dev_req_o && dev_addr_o == ADDR_TC |-> !dev_wdata_o[7] && dev_wdata_o[0] == rev_run_q;
    endproperty
    a_tc_frame: assert property (p_tc_frame) else $error("bad 55h frame");
    property p_four_samples;
        $rose(state_q == S_CHECK) |-> $past(k_q) == 2'h3 && k_q == 2'h0;
    endproperty
    a_four_samples: assert property (p_four_samples) else $error("check before four samples");
    property p_unreach;
        $rose(unreach_q) |-> idx_q == STEP_LAST_IDX && state_q == S_IDLE;
    endproperty
    a_unreach: assert property (p_unreach) else $error("gave up early");
    property p_next_step;
        state_q == S_CHECK && !pass_w && idx_q < STEP_LAST_IDX |=> idx_q == $past(idx_q) + 3'h1 ##0 state_q == S_COARSE;
    endproperty
    a_next_step: assert property (p_next_step) else $error("step not advanced");
    property p_stop_pass;
        state_q == S_CHECK && pass_w |=> state_q == S_CDIV ##1 state_q == S_CWAIT;
    endproperty
    a_stop_pass: assert property (p_stop_pass) else $error("search did not stop");
    property p_rec_pol;
        dev_req_o && !dev_we_o && dev_addr_o < ADDR_OFFS_NVM |-> (dev_addr_o >= ADDR_REC1_R) == rev_run_q;
    endproperty
    a_rec_pol: assert property (p_rec_pol) else $error("wrong record set");
    property p_dev_hold;
        dev_req_o && !dev_ack_i |=> dev_req_o && $stable(dev_addr_o) && $stable(dev_wdata_o);
    endproperty
    a_dev_hold: assert property (p_dev_hold) else $error("device request dropped");
    property p_keep;
        state_q == S_KEEP && dev_ack_i |=> keep_q == $past(dev_rdata_i[7:5]);
    endproperty
    a_keep: assert property (p_keep) else $error("5Ah upper bits not kept");
    property p_keep_bits;
        dev_req_o && dev_addr_o == ADDR_OFFS_IMG |-> dev_wdata_o[7:5] == keep_q && dev_wdata_o[4:0] == offs_q;
    endproperty
    a_keep_bits: assert property (p_keep_bits) else $error("59h upper bits changed");
    property p_sat_hi;
        state_q == S_OWAIT && div_done && quo > 32'sd15 |=> offs_q == 5'h1f;
    endproperty
    a_sat_hi: assert property (p_sat_hi) else $error("trim not clamped");
    property p_sign;
        state_q == S_OWAIT && div_done && quo < 32'sd0 |=> !offs_q[4] && offs_q[3:0] != 4'h0;
    endproperty
    a_sign: assert property (p_sign) else $error("negative trim sign wrong");
    property p_recalc;
        $rose(state_q == S_REC1) |-> $past(state_q) == S_CWR;
    endproperty
    a_recalc: assert property (p_recalc) else $error("offset not after coefficient");
    c_unreach: cover property ($rose(unreach_q));
    c_first_pass: cover property (state_q == S_CHECK && pass_w && idx_q == 3'h0);
    c_trim_done: cover property (state_q == S_OWR && dev_ack_i);
endmodule : sgot_ctrl
`default_nettype wire

// file: tb/sgot_dev_model.sv
// device model: trim registers, shipment records, output pin sampling
// assumes the controller's register and measurement handshakes
`timescale 1ns/1ps
`default_nettype none
module sgot_dev_model
    import sgot_pkg::*;
(
    // clock, reset, expected polarity
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        pol_i,
    // register port
    input  wire logic        dev_req_i,
    input  wire logic        dev_we_i,
    input  wire logic [7:0]  dev_addr_i,
    input  wire logic [7:0]  dev_wdata_i,
    output logic [7:0]       dev_rdata_o,
    output logic             dev_ack_o,
    // measurement
    input  wire logic        meas_req_i,
    input  wire logic        meas_nominal_i,
    output logic [15:0]      meas_data_o,
    output logic             meas_ack_o
);
    logic [7:0]  mem [0:255];
    logic [1:0]  wait_q = 2'h0;
    logic [1:0]  mcnt_q = 2'h0;
    logic [15:0] smp;
    int          bad = 0;
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        mem[8'h09] = 8'h13;
        mem[8'h0a] = 8'ha8; // +40
        mem[8'h0b] = 8'h04; // -4
        mem[8'h0c] = 8'h05;
        mem[8'h0d] = 8'h64; // -100
        mem[8'h0e] = 8'h8a; // +10
        mem[8'h19] = 8'h13;
        mem[8'h59] = 8'h13;
        mem[8'h5a] = 8'ha3;
        dev_ack_o = 1'b0;
        meas_ack_o = 1'b0;
    end
    // gain rises as the coarse step falls; zero-field level offset on purpose
    assign smp = meas_nominal_i ? 16'h0100 + 16'(8 - int'(mem[ADDR_COARSE][2:0])) * 16'd100 : 16'h0100;
    // released lines show the inverse, not a stale value
    assign meas_data_o = meas_ack_o ? smp : ~smp;
    assign dev_rdata_o = dev_ack_o ? mem[dev_addr_i] : ~mem[dev_addr_i];
    always @(posedge clk_i) begin
        dev_ack_o <= 1'b0;
        meas_ack_o <= 1'b0;
        if (dev_req_i && !dev_ack_o && !rst_i) begin
            // odd addresses answer slowly
            if (wait_q == (dev_addr_i[0] ? 2'd3 : 2'd0)) begin
                dev_ack_o <= 1'b1;
                wait_q <= 2'h0;
                if (dev_we_i) mem[dev_addr_i] <= dev_wdata_i;
                if (dev_we_i && dev_addr_i == ADDR_COARSE) mcnt_q <= 2'h0;
                if (dev_we_i && dev_addr_i == ADDR_TC && (dev_wdata_i[7] || dev_wdata_i[0] !== pol_i)) bad++;
            end else begin
                wait_q <= wait_q + 2'h1;
            end
        end
        if (meas_req_i && !meas_ack_o) begin
            meas_ack_o <= 1'b1;
            mcnt_q <= mcnt_q + 2'h1;
            if (meas_nominal_i !== mcnt_q[1] || mem[ADDR_TC][6:1] !== (mcnt_q[0] ? TC_MAX : TC_MIN)) bad++;
        end
    end
endmodule : sgot_dev_model
`default_nettype wire

// file: tb/sgot_ctrl_tb.sv
// testbench for the trim controller: wishbone tasks and a table of trimming runs
// assumes the device model in tb/ and the package constants
`timescale 1ns/1ps
`default_nettype none
module sgot_ctrl_tb;
    import sgot_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic        pol = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, sts;
    logic        ack, dreq, dwe, dack, mreq, mnom, mack;
    logic [7:0]  daddr, dwdat, drdat;
    logic [15:0] mdat;
    int          failures = 0;
    int          cmp_count = 0;
    always #5 clk_i = ~clk_i;
    sgot_ctrl #(.MW(16)) u_sgot_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_dat_o(rdat), .wb_ack_o(ack),
        .dev_req_o(dreq), .dev_we_o(dwe), .dev_addr_o(daddr), .dev_wdata_o(dwdat), .dev_rdata_i(drdat),
        .dev_ack_i(dack), .meas_req_o(mreq), .meas_nominal_o(mnom), .meas_data_i(mdat), .meas_ack_i(mack));
    sgot_dev_model u_sgot_dev_model (.clk_i(clk_i), .rst_i(rst_i), .pol_i(pol), .dev_req_i(dreq),
        .dev_we_i(dwe), .dev_addr_i(daddr), .dev_wdata_i(dwdat), .dev_rdata_o(drdat), .dev_ack_o(dack),
        .meas_req_i(mreq), .meas_nominal_i(mnom), .meas_data_o(mdat), .meas_ack_o(mack));
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one classic cycle; held until ack is sampled high
    task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {2'b00, a};
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1 && ++n < 50);
        if (ack !== 1'b1) begin
            failures++;
            tally_and_finish;
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic run(input logic p, input logic [15:0] tgt, input logic [15:0] ct, input logic [15:0] cs,
                       input logic [31:0] es, input logic [31:0] mk, input logic [7:0] e59);
        int n;
        n = 0;
        pol <= p;
        wb(1'b1, REG_SENS, {16'h0, tgt}, sts);
        wb(1'b1, REG_FIELD, 32'h1, sts);
        wb(1'b1, REG_CTGT, {16'h0, ct}, sts);
        wb(1'b1, REG_CSTEP, {16'h0, cs}, sts);
        wb(1'b1, REG_CTRL, {30'h0, p, 1'b1}, sts);
        wb(1'b0, REG_STAT, 32'h0, sts);
        chk(sts & 32'h4000, 32'h4000);
        do wb(1'b0, REG_STAT, 32'h0, sts); while (sts[15] !== 1'b1 && ++n < 3000);
        chk(sts & mk, es);
        if (e59 != 8'h00) chk({24'h0, u_sgot_dev_model.mem[ADDR_OFFS_IMG]}, {24'h0, e59});
    endtask : run
    initial begin
        #300000;
        failures++;
        tally_and_finish;
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, REG_CSTEP, 32'h0, sts);
        chk(sts, 32'h1);
        wb(1'b0, 6'h3c, 32'h0, sts);
        chk(sts, 32'h0);
        // step 5, step 6 reversed half rounding, step 7 coef clamped, step 1, step 2 reversed, trim clamped, unreachable
        run(1'b0, 16'd250, 16'd64, 16'd4, 32'h0000aa16, 32'h1ffff, 8'hb6);
        run(1'b1, 16'd150, 16'd302, 16'd10, 32'h0000b0af, 32'h1ffff, 8'haf);
        run(1'b0, 16'd50, 16'hffd6, 16'd4, 32'h0000bc36, 32'h1ffff, 8'hb6);
        run(1'b0, 16'd650, 16'd64, 16'd4, 32'h00008a13, 32'h1ffff, 8'hb3);
        run(1'b1, 16'd550, 16'd64, 16'd4, 32'h0000920d, 32'h1ffff, 8'had);
        // +127 in the normal second record drives the trim past fifteen
        u_sgot_dev_model.mem[ADDR_REC2_N] <= 8'hff;
        run(1'b0, 16'd250, 16'd64, 16'd4, 32'h0000aa1f, 32'h1ffff, 8'hbf);
        run(1'b0, 16'd800, 16'd64, 16'd4, 32'h00018000, 32'h1c000, 8'h00);
        chk(32'(u_sgot_dev_model.bad), 32'h0);
        tally_and_finish;
    end
endmodule : sgot_ctrl_tb
`default_nettype wire
